// [logic/lpsi_top.sv]
`timescale 1ns/1ps
// Behaviour
// - Seventeen byte registers are all reachable over the two-wire bus.
// - The port works at standard, fast and high-speed bus rates.
// - Only the fixed seven-bit target address 13h is answered.
// - Address byte 26h selects a write and 27h selects a read.
// - Register indices 80h to 90h map one byte register each.
// - Writing index 80h starts light or proximity measurements.
// - The command register carries the light ready flag in bit 6 and proximity in bit 5.
// - The light ready flag sets on a new light result and clears on reading either light result byte.
// - The interrupt pin is open drain: it pulls low to signal and otherwise releases.
// - The proximity ready flag sets on a new result and clears on reading either proximity byte.
// - Self-timed enable starts the sequencer, and single shots are ignored while it is set.
// - One write setting both single-shot bits starts both measurements together.
module lpsi_top
    import lpsi_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = LPSI_ID_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_int_assert,
    output logic o_int_out,
    output logic o_int_oe_n,
    input wire logic i_light_valid,
    input wire logic [15:0] i_light_result,
    input wire logic i_near_valid,
    input wire logic [15:0] i_near_result,
    output logic o_light_start,
    output logic o_near_start,
    output logic o_self_timed_en,
    output logic o_light_periodic_en,
    output logic o_near_periodic_en
);

    lpsi_link_if lnk ();

    logic scl_s1_r, scl_s2_r, scl_d3_r;
    logic sda_s1_r, sda_s2_r, sda_d3_r;
    logic link_hold_r;
    logic tgl_s1_r, tgl_s2_r, tgl_d3_r;
    logic [7:0] rdata_r;
    logic [7:0] plain_r [LPSI_REG_COUNT];
    logic [15:0] light_res_r, near_res_r;
    logic self_timed_r, light_per_r, near_per_r;
    logic light_ss_r, near_ss_r, light_rdy_r, near_rdy_r;
    logic light_start_r, near_start_r, int_oe_n_r;

    // --------------------------------------------------------------
    // Bus condition watch; start or stop holds the link logic in reset
    // --------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d3_r <= 1'b1;
        end else begin
            scl_s1_r <= i_scl;
            scl_s2_r <= scl_s1_r;
            scl_d3_r <= scl_s2_r;
            sda_s1_r <= i_sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d3_r <= sda_s2_r;
        end
    end

    wire logic scl_high = scl_s2_r && scl_d3_r;
    wire logic bus_cond = scl_high && (sda_s2_r != sda_d3_r);
    wire logic hold_nxt = bus_cond || (link_hold_r && scl_s2_r);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_hold_r <= 1'b1;
        end else begin
            link_hold_r <= hold_nxt;
        end
    end

    wire logic link_rst_n = i_reset_n && !link_hold_r;

    // The bit engine runs on the bus clock itself, but read data from the i_clk side must arrive within one bus clock high phase.
    lpsi_link u_link (
        .i_scl(i_scl),
        .i_reset_n(i_reset_n),
        .i_link_rst_n(link_rst_n),
        .i_sda_in(i_sda_in),
        .o_sda_oe_n(o_sda_oe_n),
        .lnk(lnk.link)
    );

    // --------------------------------------------------------------
    // Request crossing: toggle synchronised, fields quasi-static
    // --------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_d3_r <= 1'b0;
        end else begin
            tgl_s1_r <= lnk.req_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_d3_r <= tgl_s2_r;
        end
    end

    wire logic req_pulse = tgl_s2_r ^ tgl_d3_r;
    wire logic [7:0] rel_index = lnk.req_index - LPSI_REG_FIRST;
    wire logic in_range = (lnk.req_index >= LPSI_REG_FIRST)
                          && (lnk.req_index <= LPSI_REG_LAST);
    wire logic [4:0] idx = rel_index[4:0];
    wire logic wr_hit = req_pulse && lnk.req_write && in_range;
    wire logic rd_hit = req_pulse && !lnk.req_write && in_range;
    wire logic wr_cmd = wr_hit && (idx == LPSI_IDX_CMD);
    wire logic res_reg = (idx >= LPSI_IDX_LIGHT_HI) && (idx <= LPSI_IDX_NEAR_LO);
    wire logic wr_plain = wr_hit && (idx != LPSI_IDX_CMD) && (idx != LPSI_IDX_ID) && !res_reg;
    wire logic [7:0] wd = lnk.req_wdata;

    // --------------------------------------------------------------
    // Command register
    // --------------------------------------------------------------
    wire logic shot_ok = wr_cmd && !self_timed_r && !wd[LPSI_CMD_SELF_TIMED];
    wire logic light_go = shot_ok && wd[LPSI_CMD_LIGHT_SS];
    wire logic near_go = shot_ok && wd[LPSI_CMD_NEAR_SS];
    wire logic light_clr = rd_hit && ((idx == LPSI_IDX_LIGHT_HI) || (idx == LPSI_IDX_LIGHT_LO));
    wire logic near_clr = rd_hit && ((idx == LPSI_IDX_NEAR_HI) || (idx == LPSI_IDX_NEAR_LO));
    wire logic light_rdy_nxt = i_light_valid || (light_rdy_r && !light_clr);
    wire logic near_rdy_nxt = i_near_valid || (near_rdy_r && !near_clr);
    wire logic light_ss_nxt = light_go || (light_ss_r && !i_light_valid);
    wire logic near_ss_nxt = near_go || (near_ss_r && !i_near_valid);

    wire logic [7:0] cmd_value = {1'b1, light_rdy_r, near_rdy_r, light_ss_r, near_ss_r,
                                  light_per_r, near_per_r, self_timed_r};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            self_timed_r <= 1'b0;
            light_per_r <= 1'b0;
            near_per_r <= 1'b0;
        end else if (wr_cmd) begin
            self_timed_r <= wd[LPSI_CMD_SELF_TIMED];
            light_per_r <= wd[LPSI_CMD_LIGHT_PER];
            near_per_r <= wd[LPSI_CMD_NEAR_PER];
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            light_rdy_r <= 1'b0;
            near_rdy_r <= 1'b0;
            light_ss_r <= 1'b0;
            near_ss_r <= 1'b0;
            light_start_r <= 1'b0;
            near_start_r <= 1'b0;
        end else begin
            light_rdy_r <= light_rdy_nxt;
            near_rdy_r <= near_rdy_nxt;
            light_ss_r <= light_ss_nxt;
            near_ss_r <= near_ss_nxt;
            light_start_r <= light_go;
            near_start_r <= near_go;
        end
    end

    // --------------------------------------------------------------
    // Result and plain registers
    // --------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            light_res_r <= 16'h0000;
            near_res_r <= 16'h0000;
        end else begin
            if (i_light_valid) begin
                light_res_r <= i_light_result;
            end
            if (i_near_valid) begin
                near_res_r <= i_near_result;
            end
        end
    end

    // Only the plain entries are used; result, identity and command entries stay unwritten.
    generate
        for (genvar g = 0; g < LPSI_REG_COUNT; g++) begin : g_plain
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    plain_r[g] <= LPSI_PLAIN_RESET;
                end else if (wr_plain && (idx == 5'(g))) begin
                    plain_r[g] <= wd;
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    wire logic [7:0] rd_value =
        !in_range ? 8'h00 :
        (idx == LPSI_IDX_CMD) ? cmd_value :
        (idx == LPSI_IDX_ID) ? ID_VALUE :
        (idx == LPSI_IDX_LIGHT_HI) ? light_res_r[15:8] :
        (idx == LPSI_IDX_LIGHT_LO) ? light_res_r[7:0] :
        (idx == LPSI_IDX_NEAR_HI) ? near_res_r[15:8] :
        (idx == LPSI_IDX_NEAR_LO) ? near_res_r[7:0] :
        plain_r[idx];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= 8'h00;
        end else if (req_pulse && !lnk.req_write) begin
            rdata_r <= rd_value;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            int_oe_n_r <= 1'b1;
        end else begin
            int_oe_n_r <= ~i_int_assert;
        end
    end

    assign lnk.rdata = rdata_r;
    assign o_sda_out = 1'b0;
    assign o_int_out = 1'b0;
    assign o_int_oe_n = int_oe_n_r;
    assign o_light_start = light_start_r;
    assign o_near_start = near_start_r;
    assign o_self_timed_en = self_timed_r;
    assign o_light_periodic_en = light_per_r;
    assign o_near_periodic_en = near_per_r;

endmodule : lpsi_top

// [logic/lpsi_pkg.sv]
package lpsi_pkg;

    // --------------------------------------------------------------
    // Bus addressing
    // --------------------------------------------------------------
    localparam logic [6:0] LPSI_TARGET_ADDR = 7'h13;
    localparam logic [7:0] LPSI_WRITE_BYTE = 8'h26;
    localparam logic [7:0] LPSI_READ_BYTE = 8'h27;
    localparam logic [7:0] LPSI_REG_FIRST = 8'h80;
    localparam logic [7:0] LPSI_REG_LAST = 8'h90;
    localparam int LPSI_REG_COUNT = 17;

    // --------------------------------------------------------------
    // Register indices relative to the first register
    // --------------------------------------------------------------
    localparam logic [4:0] LPSI_IDX_CMD = 5'h00;
    localparam logic [4:0] LPSI_IDX_ID = 5'h01;
    localparam logic [4:0] LPSI_IDX_LIGHT_HI = 5'h05;
    localparam logic [4:0] LPSI_IDX_LIGHT_LO = 5'h06;
    localparam logic [4:0] LPSI_IDX_NEAR_HI = 5'h07;
    localparam logic [4:0] LPSI_IDX_NEAR_LO = 5'h08;

    // --------------------------------------------------------------
    // Command register fields
    // --------------------------------------------------------------
    localparam int LPSI_CMD_LOCK = 7;
    localparam int LPSI_CMD_LIGHT_RDY = 6;
    localparam int LPSI_CMD_NEAR_RDY = 5;
    localparam int LPSI_CMD_LIGHT_SS = 4;
    localparam int LPSI_CMD_NEAR_SS = 3;
    localparam int LPSI_CMD_LIGHT_PER = 2;
    localparam int LPSI_CMD_NEAR_PER = 1;
    localparam int LPSI_CMD_SELF_TIMED = 0;
    localparam logic [7:0] LPSI_PLAIN_RESET = 8'h00;

    // Identity byte; the value is arbitrary.
    localparam logic [7:0] LPSI_ID_DEFAULT = 8'hA5;

    // --------------------------------------------------------------
    // Link byte framing
    // --------------------------------------------------------------
    localparam logic [3:0] LPSI_ACK_SLOT = 4'h8;
    localparam logic [3:0] LPSI_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        LPSI_ST_ADDR = 3'b000,
        LPSI_ST_INDEX = 3'b001,
        LPSI_ST_WDATA = 3'b010,
        LPSI_ST_RDATA = 3'b011,
        LPSI_ST_IGNORE = 3'b100
    } lpsi_state_t;

endpackage : lpsi_pkg

// [logic/lpsi_link_if.sv]
`timescale 1ns/1ps
interface lpsi_link_if;
    logic req_tgl;
    logic req_write;
    logic [7:0] req_index;
    logic [7:0] req_wdata;
    logic [7:0] rdata;

    modport link (output req_tgl, output req_write, output req_index, output req_wdata,
                  input rdata);
    modport core (input req_tgl, input req_write, input req_index, input req_wdata,
                  output rdata);
endinterface : lpsi_link_if

// [logic/lpsi_link.sv]
`timescale 1ns/1ps
module lpsi_link
    import lpsi_pkg::*;
(
    input wire logic i_scl,
    input wire logic i_reset_n,
    input wire logic i_link_rst_n,
    input wire logic i_sda_in,
    output logic o_sda_oe_n,
    lpsi_link_if.link lnk
);

    lpsi_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] index_r;
    logic [7:0] req_index_r;
    logic [7:0] req_wdata_r;
    logic req_write_r;
    logic req_tgl_r;
    logic sda_oe_n_r;

    // --------------------------------------------------------------
    // Byte decode
    // --------------------------------------------------------------
    wire logic at_ack = (cnt_r == LPSI_ACK_SLOT);
    wire logic addr_hit = (shift_r[7:1] == LPSI_TARGET_ADDR);
    wire logic is_read = shift_r[0];
    wire logic ack_ok = (state_r == LPSI_ST_ADDR) ? addr_hit :
                        ((state_r == LPSI_ST_INDEX) || (state_r == LPSI_ST_WDATA));
    wire logic [2:0] tx_bit = 3'h7 - cnt_r[2:0];
    wire logic tx_low = (state_r == LPSI_ST_RDATA) && !at_ack && !lnk.rdata[tx_bit];
    wire logic drive_low = (at_ack && ack_ok) || tx_low;
    wire logic do_read = at_ack && (((state_r == LPSI_ST_ADDR) && addr_hit && is_read) ||
                                    ((state_r == LPSI_ST_RDATA) && !i_sda_in));
    wire logic do_write = at_ack && (state_r == LPSI_ST_WDATA);

    // --------------------------------------------------------------
    // Receive side, sampled on the rising bus clock
    // --------------------------------------------------------------
    always_ff @(posedge i_scl or negedge i_link_rst_n) begin
        if (!i_link_rst_n) begin
            state_r <= LPSI_ST_ADDR;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (at_ack) begin
            cnt_r <= 4'h0;
            unique case (state_r)
                LPSI_ST_ADDR: begin
                    state_r <= !addr_hit ? LPSI_ST_IGNORE :
                               (is_read ? LPSI_ST_RDATA : LPSI_ST_INDEX);
                end
                LPSI_ST_INDEX: state_r <= LPSI_ST_WDATA;
                LPSI_ST_WDATA: state_r <= LPSI_ST_WDATA;
                LPSI_ST_RDATA: state_r <= i_sda_in ? LPSI_ST_IGNORE : LPSI_ST_RDATA;
                LPSI_ST_IGNORE: state_r <= LPSI_ST_IGNORE;
                default: state_r <= LPSI_ST_IGNORE;
            endcase
        end else begin
            cnt_r <= cnt_r + 4'h1;
            shift_r <= {shift_r[6:0], i_sda_in};
        end
    end

    // The index survives a repeated start so that a read follows its index write.
    always_ff @(posedge i_scl or negedge i_reset_n) begin
        if (!i_reset_n) begin
            index_r <= 8'h00;
            req_index_r <= 8'h00;
            req_wdata_r <= 8'h00;
            req_write_r <= 1'b0;
            req_tgl_r <= 1'b0;
        end else if (at_ack && (state_r == LPSI_ST_INDEX) && i_link_rst_n) begin
            index_r <= shift_r;
        end else if ((do_read || do_write) && i_link_rst_n) begin
            req_index_r <= index_r;
            req_wdata_r <= shift_r;
            req_write_r <= do_write;
            req_tgl_r <= ~req_tgl_r;
            index_r <= index_r + 8'h01;
        end
    end

    // --------------------------------------------------------------
    // Transmit side, changed on the falling bus clock
    // --------------------------------------------------------------
    always_ff @(negedge i_scl or negedge i_link_rst_n) begin
        if (!i_link_rst_n) begin
            sda_oe_n_r <= 1'b1;
        end else begin
            sda_oe_n_r <= ~drive_low;
        end
    end

    assign o_sda_oe_n = sda_oe_n_r;
    assign lnk.req_tgl = req_tgl_r;
    assign lnk.req_write = req_write_r;
    assign lnk.req_index = req_index_r;
    assign lnk.req_wdata = req_wdata_r;

endmodule : lpsi_link

// [test/lpsi_top_asserts.sv]
`timescale 1ns/1ps
module lpsi_top_asserts (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic i_int_assert,
    input wire logic o_int_out,
    input wire logic o_int_oe_n,
    input wire logic o_light_start,
    input wire logic o_near_start,
    input wire logic o_self_timed_en,
    input wire logic o_light_periodic_en,
    input wire logic o_near_periodic_en
);
    // ----------------------------------------------------------------
    // Cycles since the last bus clock edge, saturating.
    // ----------------------------------------------------------------
    logic [5:0] idle_r;
    logic scl_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idle_r <= 6'h00;
            scl_r <= 1'b1;
        end else begin
            scl_r <= i_scl;
            idle_r <= (i_scl != scl_r) ? 6'h00 : idle_r + {5'h00, idle_r != 6'h3F};
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    int_drive_a: assert property (i_int_assert |=> !o_int_oe_n)
        else $error("interrupt pin not pulled low");
    int_release_a: assert property (!i_int_assert |=> o_int_oe_n)
        else $error("interrupt pin not released");
    int_level_a: assert property (o_int_out == 1'b0)
        else $error("interrupt pin driven high");
    sda_level_a: assert property (o_sda_out == 1'b0)
        else $error("data pin driven high");
    sda_edge_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
        else $error("data drive changed while bus clock high");
    shot_block_a: assert property ($past(o_self_timed_en) && o_self_timed_en
        |-> !(o_light_start || o_near_start))
        else $error("single shot started in self-timed mode");
    light_pulse_a: assert property (o_light_start |=> !o_light_start)
        else $error("light start longer than one cycle");
    near_pulse_a: assert property (o_near_start |=> !o_near_start)
        else $error("proximity start longer than one cycle");
    enables_idle_a: assert property (idle_r > 6'h14 |->
        $stable({o_self_timed_en, o_light_periodic_en, o_near_periodic_en}))
        else $error("enable changed without bus traffic");
    starts_idle_a: assert property (idle_r > 6'h14 |-> !o_light_start && !o_near_start)
        else $error("start pulse without bus traffic");
endmodule : lpsi_top_asserts

bind lpsi_top lpsi_top_asserts u_asserts (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .i_int_assert(i_int_assert), .o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n),
    .o_light_start(o_light_start), .o_near_start(o_near_start),
    .o_self_timed_en(o_self_timed_en), .o_light_periodic_en(o_light_periodic_en),
    .o_near_periodic_en(o_near_periodic_en));

// [test/lpsi_host.sv]
`timescale 1ns/1ps
module lpsi_host (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe_n,
    output logic o_res_stb,
    output logic [8:0] o_res
);
    // ----------------------------------------------------------------
    // Bus controller; the clock stands high between frames.
    // ----------------------------------------------------------------
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
        o_res_stb = 1'b0;
        o_res = 9'h000;
    end
    // High phase is long so the target can fetch read data in time.
    task automatic bit_io(input logic b, output logic s);
        #5 o_sda_oe_n = b;
        #5 o_scl = 1'b1;
        s = i_sda;
        #22 o_scl = 1'b0;
    endtask : bit_io
    task automatic start();
        #5 o_sda_oe_n = 1'b1;
        #5 o_scl = 1'b1;
        #40 o_sda_oe_n = 1'b0;
        #40 o_scl = 1'b0;
        #20;
    endtask : start
    task automatic stop();
        #5 o_sda_oe_n = 1'b0;
        #5 o_scl = 1'b1;
        #40 o_sda_oe_n = 1'b1;
        #200;
    endtask : stop
    task automatic report(input logic [8:0] v);
        o_res = v;
        o_res_stb = 1'b1;
        #1 o_res_stb = 1'b0;
    endtask : report
    task automatic send_byte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        report({1'b1, 7'h00, s});
    endtask : send_byte
    task automatic recv_byte(input logic nack);
        logic s;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
        report({1'b0, d});
    endtask : recv_byte
endmodule : lpsi_host

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import lpsi_pkg::*;
    localparam logic [8:0] ACKED = 9'h100;
    localparam logic [7:0] CMD = LPSI_REG_FIRST;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic int_assert = 1'b0;
    logic light_valid = 1'b0;
    logic near_valid = 1'b0;
    logic [15:0] light_result = 16'h0000;
    logic [15:0] near_result = 16'h0000;
    logic sda_out, dut_oe_n, int_out, int_oe_n, light_start, near_start;
    logic st_en, lp_en, np_en, scl, host_oe_n, res_stb;
    logic [8:0] res;
    logic [8:0] expq[$];
    wire sda;
    int n_fail = 0;
    int compares = 0;
    int n_ls = 0;
    int n_ns = 0;
    int n_both = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    // Open-drain data line with a pull-up.
    assign sda = host_oe_n & (dut_oe_n | sda_out);
    lpsi_top dut (.i_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda_in(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(dut_oe_n), .i_int_assert(int_assert),
        .o_int_out(int_out), .o_int_oe_n(int_oe_n), .i_light_valid(light_valid),
        .i_light_result(light_result), .i_near_valid(near_valid),
        .i_near_result(near_result), .o_light_start(light_start),
        .o_near_start(near_start), .o_self_timed_en(st_en),
        .o_light_periodic_en(lp_en), .o_near_periodic_en(np_en));
    lpsi_host host (.i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n),
        .o_res_stb(res_stb), .o_res(res));
    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("Error at %0t ns: expected %h, got %h", $time, e, g);
        end
    endtask : cmp
    always @(posedge res_stb) begin
        if (expq.size() == 0) begin
            cmp(16'hFFFF, {7'h00, res});
        end else begin
            cmp({7'h00, expq.pop_front()}, {7'h00, res});
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (light_start === 1'b1) n_ls++;
        if (near_start === 1'b1) n_ns++;
        if (light_start === 1'b1 && near_start === 1'b1) n_both++;
        if (cycles == 40000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        repeat (3) expq.push_back(ACKED);
        host.start();
        host.send_byte(LPSI_WRITE_BYTE);
        host.send_byte(idx);
        host.send_byte(d);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        repeat (3) expq.push_back(ACKED);
        expq.push_back({1'b0, e});
        host.start();
        host.send_byte(LPSI_WRITE_BYTE);
        host.send_byte(idx);
        host.start();
        host.send_byte(LPSI_READ_BYTE);
        host.recv_byte(1'b1);
        host.stop();
    endtask : rd
    task automatic result(input logic near, input logic [15:0] v);
        @(posedge clk);
        #1;
        near_result = v;
        light_result = v;
        near_valid = near;
        light_valid = !near;
        @(posedge clk);
        #1;
        near_valid = 1'b0;
        light_valid = 1'b0;
    endtask : result
    initial begin
        logic [7:0] d;
        logic [15:0] lv;
        logic [15:0] nv;
        void'($urandom(1974));
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        rd(CMD, 8'h80);
        rd(8'h81, LPSI_ID_DEFAULT);
        // The identity byte is read only, so this write must leave it alone.
        wr(8'h81, 8'h00);
        rd(8'h81, LPSI_ID_DEFAULT);
        // Rate registers are written here, while self-timed mode is off.
        for (int i = 2; i < LPSI_REG_COUNT; i++) begin
            if (i < 5 || i > 8) begin
                d = 8'($urandom);
                wr(CMD + 8'(i), d);
                rd(CMD + 8'(i), d);
            end
        end
        rd(8'h91, 8'h00);
        for (int k = 0; k < 7; k++) begin
            expq.push_back(9'h101);
            host.start();
            host.send_byte({LPSI_TARGET_ADDR ^ 7'(1 << k), 1'b0});
            host.stop();
        end
        wr(CMD, 8'h18);
        cmp(16'(n_both), 16'h0001);
        rd(CMD, 8'h98);
        lv = 16'($urandom);
        nv = 16'($urandom);
        result(1'b0, lv);
        rd(CMD, 8'hC8);
        result(1'b1, nv);
        rd(CMD, 8'hE0);
        rd(8'h86, lv[7:0]);
        rd(CMD, 8'hA0);
        rd(8'h87, nv[15:8]);
        rd(CMD, 8'h80);
        wr(CMD, 8'h05);
        cmp({13'h0000, lp_en, np_en, st_en}, 16'h0005);
        wr(CMD, 8'h1B);
        cmp(16'(n_ls + n_ns), 16'h0002);
        cmp({13'h0000, lp_en, np_en, st_en}, 16'h0003);
        rd(CMD, 8'h83);
        @(posedge clk);
        #1 int_assert = 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp({14'h0000, int_oe_n, int_out}, 16'h0000);
        int_assert = 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({14'h0000, int_oe_n, int_out}, 16'h0002);
        // A reset in mid-run returns the command register to its idle value.
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        cmp({13'h0000, lp_en, np_en, st_en}, 16'h0000);
        repeat (3) @(posedge clk);
        rd(CMD, 8'h80);
        // Self-timed set in the same write as the shots blocks both shots.
        wr(CMD, 8'h19);
        cmp(16'(n_ls + n_ns), 16'h0002);
        rd(CMD, 8'h81);
        cmp(16'(expq.size()), 16'h0000);
        conclude();
    end
endmodule : testbench
